// [src/lcc_common_ctrl.sv]
// Two common control registers of one line-interface channel
`timescale 1ns/1ps
`include "lcc_defs.svh"
module lcc_common_ctrl
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Host register port
  input wire logic host_cs_n_in,
  input wire logic host_wr_n_in,
  input wire logic host_rd_n_in,
  input wire logic [4:0] host_addr_in,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_out,
  // Clock sources
  input wire logic master_clock_in,
  input wire logic pll_clock_in,
  input wire logic tx_line_clock_in,
  input wire logic rx_line_clock_in,
  output logic jitter_attenuator_clock_out,
  output logic rx_recovered_clock_out,
  output logic tx_logic_clock_out,
  // Transmit system rails
  input wire logic tx_positive_rail_in,
  input wire logic tx_negative_rail_in,
  output logic tx_sampled_pos_out,
  output logic tx_sampled_neg_out,
  // Receive line pulses and system rails
  input wire logic rx_line_pos_in,
  input wire logic rx_line_neg_in,
  output logic rx_positive_rail_out,
  output logic rx_negative_rail_out,
  // Mode and status
  input wire logic hardware_mode_in,
  input wire logic [2:0] build_out_select_in,
  output logic alarm_out,
  output logic carrier_loss_out,
  output logic current_limit_enable_out,
  output logic square_wave_out,
  output logic open_drain_out,
  output logic rx_zero_subst_enable_out,
  output logic tx_zero_subst_enable_out,
  output logic e1_t1_select_out,
  output logic nrz_format_enable_out
);

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  lcc_sync_if #(.W(`LCC_SYNC_W)) sy ();

  // Strobes enter inverted so the cleared stages match their idle level
  lcc_sync u_sync (
    .mclk_in (mclk_in),
    .rst_n_in (rst_n_in),
    .pins_in ({host_data_in, host_addr_in, hardware_mode_in,
               ~host_rd_n_in, ~host_wr_n_in, ~host_cs_n_in,
               rx_line_neg_in, rx_line_pos_in,
               tx_negative_rail_in, tx_positive_rail_in,
               pll_clock_in, master_clock_in,
               rx_line_clock_in, tx_line_clock_in}),
    .sy (sy.src)
  );

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a,
                               input logic [4:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [4:0] a,
                                        input lcc_state_t s);
    rd_mux = 8'h00;
    if (hit(a, `LCC_COMMON_CONTROL_ONE_OFF)) begin
      rd_mux = s.common_control_one;
    end else if (hit(a, `LCC_COMMON_CONTROL_TWO_OFF)) begin
      rd_mux = s.common_control_two;
    end else if (hit(a, `LCC_ECNT_HI_OFF)) begin
      rd_mux = s.err_snap[15:8];
    end else if (hit(a, `LCC_ECNT_LO_OFF)) begin
      rd_mux = s.err_snap[7:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Shorthands
  // ------------------------------------------------------------
  lcc_state_t st;
  lcc_state_t next_st;
  logic txc;
  logic rxc;
  logic e1_t1_select;
  logic [4:0] addr;
  logic [`LCC_ZRUN_W-1:0] cl_thr;
  logic [`LCC_ZRUN_W-1:0] exz_thr;
  logic [`LCC_ZRUN_W-1:0] excuse_run;

  assign txc = sy.lvl[`LCC_SI_TXC];
  assign rxc = sy.lvl[`LCC_SI_RXC];
  assign e1_t1_select = st.common_control_one[`LCC_B_ETS];
  assign addr = sy.lvl[`LCC_SI_ADDR +: 5];
  assign exz_thr = e1_t1_select ? `LCC_EXZ_T1 : `LCC_EXZ_E1;
  assign excuse_run = e1_t1_select ? 12'h003 : 12'h002;
  always_comb begin
    if (st.common_control_one[`LCC_B_CARRIER_LOSS_ALT_CRITERIA]) begin
      cl_thr = e1_t1_select ? `LCC_CL_T1_ALT : `LCC_CL_E1_ALT;
    end else begin
      cl_thr = e1_t1_select ? `LCC_CL_T1 : `LCC_CL_E1;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic pos;
    logic neg;
    logic mark;
    logic cv;
    logic bpv;
    logic excessive_zeros;
    logic evt;
    logic rck;
    logic upd;
    logic jck;
    logic tck;
    logic smp;
    jck = 1'b0;
    pos = sy.lvl[`LCC_SI_RLP];
    neg = sy.lvl[`LCC_SI_RLN];
    mark = pos ^ neg;
    cv = pos & neg;
    bpv = mark && st.mark_seen && (pos == st.last_pos) &&
          !(!st.common_control_two[`LCC_B_RZSD] && st.zero_run >= excuse_run);
    excessive_zeros = !mark && !cv && (st.zero_run + 12'h001 == exz_thr);
    evt = bpv || cv || excessive_zeros;
    next_st = st;

    // Host writes and reads
    if (sy.lvl[`LCC_SI_CS] && sy.fall[`LCC_SI_WR]) begin
      if (hit(addr, `LCC_COMMON_CONTROL_ONE_OFF)) begin
        next_st.common_control_one = sy.lvl[`LCC_SI_DATA +: 8];
      end
      if (hit(addr, `LCC_COMMON_CONTROL_TWO_OFF)) begin
        next_st.common_control_two = sy.lvl[`LCC_SI_DATA +: 8];
      end
    end
    next_st.data_oe = sy.lvl[`LCC_SI_CS] && sy.lvl[`LCC_SI_RD];
    next_st.rd_data = rd_mux(addr, st);

    // Receive decode on each receive line clock
    if (sy.rise[`LCC_SI_RXC]) begin
      if (mark || cv) begin
        next_st.zero_run = '0;
        next_st.carrier_loss = 1'b0;
      end else begin
        if (st.zero_run != {`LCC_ZRUN_W{1'b1}}) begin
          next_st.zero_run = st.zero_run + 12'h001;
        end
        if (st.zero_run + 12'h001 >= cl_thr) begin
          next_st.carrier_loss = 1'b1;
        end
      end
      if (mark) begin
        next_st.last_pos = pos;
        next_st.mark_seen = 1'b1;
      end
      if (st.snap_pending) begin
        next_st.err_snap = st.err_run;
        next_st.err_run = {15'h0000, evt};
        next_st.snap_pending = 1'b0;
      end else if (evt && st.err_run != 16'hFFFF) begin
        next_st.err_run = st.err_run + 16'h0001;
      end
      if (st.common_control_one[`LCC_B_NRZ]) begin
        next_st.pend_pos = mark;
        next_st.pend_neg = evt;
      end else begin
        next_st.pend_pos = pos;
        next_st.pend_neg = neg;
      end
    end

    // Snapshot request, set wins over the clear above
    next_st.error_counter_update_prev = st.common_control_one[`LCC_B_ERROR_COUNTER_UPDATE];
    if (st.common_control_one[`LCC_B_ERROR_COUNTER_UPDATE] && !st.error_counter_update_prev) begin
      next_st.snap_pending = 1'b1;
    end

    // Recovered clock and receive rail update
    rck = st.common_control_one[`LCC_B_TX_CLOCK_TO_RX_CLOCK] ? txc : rxc;
    next_st.rclk = rck;
    upd = st.common_control_two[`LCC_B_RX_UPDATE_EDGE_SELECT] ? (!rck && st.rclk) : (rck && !st.rclk);
    if (upd) begin
      next_st.rx_pos = st.pend_pos;
      next_st.rx_neg = st.pend_neg;
    end

    // Jitter attenuator clock
    if (st.common_control_one[`LCC_B_TX_CLOCK_TO_JITTER_CLOCK]) begin
      jck = txc;
    end else if (st.common_control_one[`LCC_B_JITTER_CLOCK_MUX]) begin
      jck = sy.lvl[`LCC_SI_PLL];
    end else begin
      jck = sy.lvl[`LCC_SI_MCK];
    end
    next_st.jclk = jck;

    // Transmit clock loss timer
    if (sy.rise[`LCC_SI_TXC] || sy.fall[`LCC_SI_TXC]) begin
      next_st.tx_idle = '0;
    end else if (st.tx_idle < `LCC_IDLE_W'(`LCC_LOTC_CYC)) begin
      next_st.tx_idle = st.tx_idle + 7'h01;
    end
    next_st.tx_lost = next_st.tx_idle >= `LCC_IDLE_W'(`LCC_LOTC_CYC);

    // Transmit clock failover and rail sampling
    tck = (st.common_control_one[`LCC_B_FAIL] && st.tx_lost) ? jck : txc;
    next_st.tx_line_clock = tck;
    smp = st.common_control_two[`LCC_B_TX_SAMPLE_EDGE_SELECT] ? (tck && !st.tx_line_clock) : (!tck && st.tx_line_clock);
    if (smp) begin
      next_st.tx_pos = sy.lvl[`LCC_SI_TXP];
      next_st.tx_neg = sy.lvl[`LCC_SI_TXN];
    end

    // Alarm pin and driver controls
    if (st.common_control_two[`LCC_B_ALSEL] && !sy.lvl[`LCC_SI_HW]) begin
      next_st.alarm = st.tx_lost;
    end else begin
      next_st.alarm = st.carrier_loss;
    end
    next_st.limit_en = !(!e1_t1_select && st.common_control_two[`LCC_B_CURRENT_LIMIT_DISABLE]);
    next_st.rx_subst_en = !next_st.common_control_two[`LCC_B_RZSD];
    next_st.tx_subst_en = !next_st.common_control_two[`LCC_B_TZSD];
    next_st.square = st.common_control_two[`LCC_B_CUSTOM_DRIVER_SELECT] &&
                     (build_out_select_in == 3'h0);
    next_st.open_drain = st.common_control_two[`LCC_B_CUSTOM_DRIVER_SELECT] &&
                         (build_out_select_in != 3'h0);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.common_control_one <= `LCC_CCR_RESET;
      st.common_control_two <= `LCC_CCR_RESET;
      st.limit_en <= 1'b1;
      st.rx_subst_en <= 1'b1;
      st.tx_subst_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign host_data_out = st.rd_data;
  assign host_data_oe_out = st.data_oe;
  assign jitter_attenuator_clock_out = st.jclk;
  assign rx_recovered_clock_out = st.rclk;
  assign tx_logic_clock_out = st.tx_line_clock;
  assign tx_sampled_pos_out = st.tx_pos;
  assign tx_sampled_neg_out = st.tx_neg;
  assign rx_positive_rail_out = st.rx_pos;
  assign rx_negative_rail_out = st.rx_neg;
  assign alarm_out = st.alarm;
  assign carrier_loss_out = st.carrier_loss;
  assign current_limit_enable_out = st.limit_en;
  assign square_wave_out = st.square;
  assign open_drain_out = st.open_drain;
  assign rx_zero_subst_enable_out = st.rx_subst_en;
  assign tx_zero_subst_enable_out = st.tx_subst_en;
  assign e1_t1_select_out = e1_t1_select;
  assign nrz_format_enable_out = st.common_control_one[`LCC_B_NRZ];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_nrz_events;
    @(posedge mclk_in) disable iff (!rst_n_in)
    sy.rise[`LCC_SI_RXC] && st.common_control_one[`LCC_B_NRZ] &&
      sy.lvl[`LCC_SI_RLP] && sy.lvl[`LCC_SI_RLN] |=> st.pend_neg;
  endproperty
  a_nrz_events: assert property (p_nrz_events)
    else $error("code violation not flagged in NRZ mode");

  property p_cl_base;
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(st.carrier_loss) && !st.common_control_one[`LCC_B_CARRIER_LOSS_ALT_CRITERIA] |->
      st.zero_run == (e1_t1_select ? 12'h0C0 : 12'h0FF);
  endproperty
  a_cl_base: assert property (p_cl_base)
    else $error("carrier loss raised at wrong zero count");

  property p_cl_alt;
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(st.carrier_loss) && st.common_control_one[`LCC_B_CARRIER_LOSS_ALT_CRITERIA] |->
      st.zero_run == (e1_t1_select ? 12'h608 : 12'h800);
  endproperty
  a_cl_alt: assert property (p_cl_alt)
    else $error("alternate carrier loss at wrong zero count");

  property p_snap;
    @(posedge mclk_in) disable iff (!rst_n_in)
    st.snap_pending && sy.rise[`LCC_SI_RXC] &&
      !(st.common_control_one[`LCC_B_ERROR_COUNTER_UPDATE] && !st.error_counter_update_prev) |=>
      !st.snap_pending && st.err_run <= 16'h0001 &&
      st.err_snap == $past(st.err_run);
  endproperty
  a_snap: assert property (p_snap)
    else $error("error snapshot not taken on receive clock");

  property p_jitter_src;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !st.common_control_one[`LCC_B_TX_CLOCK_TO_JITTER_CLOCK] && st.common_control_one[`LCC_B_JITTER_CLOCK_MUX] |=>
      st.jclk == $past(sy.lvl[`LCC_SI_PLL]);
  endproperty
  a_jitter_src: assert property (p_jitter_src)
    else $error("jitter clock not taken from PLL");

  property p_tx_to_jitter;
    @(posedge mclk_in) disable iff (!rst_n_in)
    st.common_control_one[`LCC_B_TX_CLOCK_TO_JITTER_CLOCK] |=> st.jclk == $past(txc);
  endproperty
  a_tx_to_jitter: assert property (p_tx_to_jitter)
    else $error("jitter clock not taken from transmit clock");

  property p_tx_to_rx;
    @(posedge mclk_in) disable iff (!rst_n_in)
    st.common_control_one[`LCC_B_TX_CLOCK_TO_RX_CLOCK] |=> st.rclk == $past(txc);
  endproperty
  a_tx_to_rx: assert property (p_tx_to_rx)
    else $error("recovered clock not taken from transmit clock");

  property p_failover;
    @(posedge mclk_in) disable iff (!rst_n_in)
    st.common_control_one[`LCC_B_FAIL] && st.tx_lost |=> st.tx_line_clock == st.jclk;
  endproperty
  a_failover: assert property (p_failover)
    else $error("transmit logic did not switch to jitter clock");

  property p_lost_edge;
    @(posedge mclk_in) disable iff (!rst_n_in)
    sy.rise[`LCC_SI_TXC] |=> !st.tx_lost [*8];
  endproperty
  a_lost_edge: assert property (p_lost_edge)
    else $error("transmit clock loss flagged while toggling");

  property p_alarm;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !st.common_control_two[`LCC_B_ALSEL] |=> st.alarm == $past(st.carrier_loss);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm does not follow carrier loss");

  property p_limit;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !e1_t1_select && st.common_control_two[`LCC_B_CURRENT_LIMIT_DISABLE] |=> !st.limit_en;
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limiter not disabled");

  property p_driver;
    @(posedge mclk_in) disable iff (!rst_n_in)
    st.common_control_two[`LCC_B_CUSTOM_DRIVER_SELECT] |=> st.square != st.open_drain;
  endproperty
  a_driver: assert property (p_driver)
    else $error("custom driver mode not exclusive");

  property p_tx_sample;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !$past(st.common_control_two[`LCC_B_TX_SAMPLE_EDGE_SELECT]) && $fell(st.tx_line_clock) |->
      st.tx_pos == $past(sy.lvl[`LCC_SI_TXP]);
  endproperty
  a_tx_sample: assert property (p_tx_sample)
    else $error("transmit rail not sampled on falling edge");

endmodule

// [src/lcc_defs.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef LCC_DEFS_SVH
`define LCC_DEFS_SVH

// ------------------------------------------------------------
// Register offsets and reset value
// ------------------------------------------------------------
`define LCC_COMMON_CONTROL_ONE_OFF 5'h00
`define LCC_COMMON_CONTROL_TWO_OFF 5'h01
`define LCC_ECNT_HI_OFF 5'h11
`define LCC_ECNT_LO_OFF 5'h12
`define LCC_CCR_RESET 8'h00

// ------------------------------------------------------------
// Field positions, first control register
// ------------------------------------------------------------
`define LCC_B_ETS 7
`define LCC_B_NRZ 6
`define LCC_B_CARRIER_LOSS_ALT_CRITERIA 5
`define LCC_B_ERROR_COUNTER_UPDATE 4
`define LCC_B_JITTER_CLOCK_MUX 3
`define LCC_B_TX_CLOCK_TO_JITTER_CLOCK 2
`define LCC_B_TX_CLOCK_TO_RX_CLOCK 1
`define LCC_B_FAIL 0

// ------------------------------------------------------------
// Field positions, second control register
// ------------------------------------------------------------
`define LCC_B_ALSEL 7
`define LCC_B_CURRENT_LIMIT_DISABLE 5
`define LCC_B_CUSTOM_DRIVER_SELECT 4
`define LCC_B_RZSD 3
`define LCC_B_TZSD 2
`define LCC_B_TX_SAMPLE_EDGE_SELECT 1
`define LCC_B_RX_UPDATE_EDGE_SELECT 0

// ------------------------------------------------------------
// Carrier loss and excessive-zero thresholds in consecutive zeros
// ------------------------------------------------------------
`define LCC_ZRUN_W 12
`define LCC_CL_E1 12'h0FF
`define LCC_CL_T1 12'h0C0
`define LCC_CL_E1_ALT 12'h800
`define LCC_CL_T1_ALT 12'h608
`define LCC_EXZ_E1 12'h004
`define LCC_EXZ_T1 12'h008
`define LCC_ECNT_W 16

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LCC_MCLK_NS 100
`define LCC_LOTC_NS 5000
`define LCC_LOTC_CYC ((`LCC_LOTC_NS + `LCC_MCLK_NS - 1) / `LCC_MCLK_NS)
`define LCC_IDLE_W 7

// ------------------------------------------------------------
// Synchroniser bit positions
// ------------------------------------------------------------
`define LCC_SYNC_W 25
`define LCC_SI_TXC 0
`define LCC_SI_RXC 1
`define LCC_SI_MCK 2
`define LCC_SI_PLL 3
`define LCC_SI_TXP 4
`define LCC_SI_TXN 5
`define LCC_SI_RLP 6
`define LCC_SI_RLN 7
`define LCC_SI_CS 8
`define LCC_SI_WR 9
`define LCC_SI_RD 10
`define LCC_SI_HW 11
`define LCC_SI_ADDR 12
`define LCC_SI_DATA 17

`endif

// [src/lcc_pkg.sv]
// State types of the common control block
package lcc_pkg;
`include "lcc_defs.svh"

  typedef struct packed {
    logic [`LCC_SYNC_W-1:0] s1;
    logic [`LCC_SYNC_W-1:0] s2;
    logic [`LCC_SYNC_W-1:0] s3;
    logic [`LCC_SYNC_W-1:0] lvl;
    logic [`LCC_SYNC_W-1:0] prev;
  } lcc_sync_st_t;

  typedef struct packed {
    logic [7:0] common_control_one;
    logic [7:0] common_control_two;
    logic error_counter_update_prev;
    logic snap_pending;
    logic [`LCC_ECNT_W-1:0] err_run;
    logic [`LCC_ECNT_W-1:0] err_snap;
    logic [`LCC_ZRUN_W-1:0] zero_run;
    logic carrier_loss;
    logic mark_seen;
    logic last_pos;
    logic pend_pos;
    logic pend_neg;
    logic rx_pos;
    logic rx_neg;
    logic rclk;
    logic jclk;
    logic tx_line_clock;
    logic [`LCC_IDLE_W-1:0] tx_idle;
    logic tx_lost;
    logic tx_pos;
    logic tx_neg;
    logic alarm;
    logic limit_en;
    logic square;
    logic open_drain;
    logic rx_subst_en;
    logic tx_subst_en;
    logic [7:0] rd_data;
    logic data_oe;
  } lcc_state_t;
endpackage

// [src/lcc_sync_if.sv]
// Synchronised pin levels and their edges
`timescale 1ns/1ps
interface lcc_sync_if #(parameter int W = 25);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// [src/lcc_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge flags
`timescale 1ns/1ps
`include "lcc_defs.svh"
module lcc_sync
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Raw pins
  input wire logic [`LCC_SYNC_W-1:0] pins_in,
  // Filtered levels and edges
  lcc_sync_if.src sy
);

  lcc_sync_st_t st;
  lcc_sync_st_t next_st;

  // ------------------------------------------------------------
  // Filter: a change counts once stages two and three agree
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.prev = st.lvl;
    for (int i = 0; i < `LCC_SYNC_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sy.lvl = st.lvl;
  assign sy.rise = st.lvl & ~st.prev;
  assign sy.fall = ~st.lvl & st.prev;

endmodule

// [sim/lcc_framer_model.sv]
// Framer model driving the transmit clock and rails
`timescale 1ns/1ps
module lcc_framer_model (
  // Control
  input wire logic run_in,
  // Transmit clock and rails
  output logic clk_out,
  output logic pos_out,
  output logic neg_out
);
  // Rails change a quarter period after each edge, so a falling
  // edge sees pos high and a rising edge sees pos low
  initial begin
    clk_out = 1'b0;
    pos_out = 1'b0;
    neg_out = 1'b1;
    #37;
    forever begin
      if (run_in) clk_out = 1'b1;
      #200;
      pos_out = 1'b1;
      neg_out = 1'b0;
      #200;
      clk_out = 1'b0;
      #200;
      pos_out = 1'b0;
      neg_out = 1'b1;
      #200;
    end
  end
endmodule

// [sim/tb_top.sv]
// Bench for the common control registers
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb_top;
  logic mclk_in = 0, rst_n_in = 0, hardware_mode_in = 0;
  logic host_cs_n_in = 1, host_wr_n_in = 1, host_rd_n_in = 1;
  logic [4:0] host_addr_in = 0;
  logic [7:0] host_data_in = 0, host_data_out, rv;
  logic master_clock_in = 0, pll_clock_in = 0, rx_line_clock_in = 0;
  logic rx_line_pos_in = 0, rx_line_neg_in = 0;
  logic [2:0] build_out_select_in = 0;
  logic host_data_oe_out, jitter_attenuator_clock_out, tx_logic_clock_out;
  logic rx_recovered_clock_out, tx_line_clock_in, tx_positive_rail_in;
  logic tx_negative_rail_in, tx_sampled_pos_out, tx_sampled_neg_out;
  logic rx_positive_rail_out, rx_negative_rail_out, alarm_out;
  logic carrier_loss_out, current_limit_enable_out, square_wave_out;
  logic open_drain_out, rx_zero_subst_enable_out, tx_zero_subst_enable_out;
  logic e1_t1_select_out, nrz_format_enable_out;
  logic mck_en = 1, pll_en = 0, tx_run = 1, sp = 0, sn = 0;
  logic [1:0] ph = 0;
  logic [7:0] cfg [4] = '{8'h00, 8'h80, 8'h20, 8'hA0};
  int zn [4] = '{255, 192, 2048, 1544};
  int err_total = 0, checks = 0, nj, nr, nt;
  wire [2:0] clks = {jitter_attenuator_clock_out, rx_recovered_clock_out,
                     tx_logic_clock_out};

  lcc_common_ctrl lcc_common_ctrl_inst (.mclk_in, .rst_n_in, .host_cs_n_in,
    .host_wr_n_in, .host_rd_n_in, .host_addr_in, .host_data_in,
    .host_data_out, .host_data_oe_out, .master_clock_in, .pll_clock_in,
    .tx_line_clock_in, .rx_line_clock_in, .jitter_attenuator_clock_out,
    .rx_recovered_clock_out, .tx_logic_clock_out, .tx_positive_rail_in,
    .tx_negative_rail_in, .tx_sampled_pos_out, .tx_sampled_neg_out,
    .rx_line_pos_in, .rx_line_neg_in, .rx_positive_rail_out,
    .rx_negative_rail_out, .hardware_mode_in, .build_out_select_in,
    .alarm_out, .carrier_loss_out, .current_limit_enable_out,
    .square_wave_out, .open_drain_out, .rx_zero_subst_enable_out,
    .tx_zero_subst_enable_out, .e1_t1_select_out, .nrz_format_enable_out);

  lcc_framer_model lcc_framer_model_inst (.run_in(tx_run),
    .clk_out(tx_line_clock_in), .pos_out(tx_positive_rail_in),
    .neg_out(tx_negative_rail_in));

  // ------------------------------------------------------------
  // Clocks and host tasks
  // ------------------------------------------------------------
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) begin
      master_clock_in <= mck_en & ~master_clock_in;
      pll_clock_in <= pll_en & ~pll_clock_in;
    end
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host_cs_n_in <= 1'b0;
    host_addr_in <= a;
    host_data_in <= d;
    @(posedge mclk_in);
    host_wr_n_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    host_wr_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    host_cs_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    host_cs_n_in <= 1'b0;
    host_rd_n_in <= 1'b0;
    host_addr_in <= a;
    repeat (6) @(posedge mclk_in);
    rv = host_data_out;
    `CHK("oe", 1'b1, host_data_oe_out)
    `CHK("reg", e, rv)
    host_cs_n_in <= 1'b1;
    host_rd_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
  endtask

  // One received bit: line clock low four cycles, then high four
  task automatic bit1(input logic p, input logic n);
    rx_line_pos_in <= p;
    rx_line_neg_in <= n;
    rx_line_clock_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) rx_line_clock_in <= 1'b1;
      @(posedge mclk_in);
      sp = sp | rx_positive_rail_out;
      sn = sn | rx_negative_rail_out;
    end
  endtask

  task automatic tog();
    logic [2:0] o;
    nj = 0;
    nr = 0;
    nt = 0;
    o = clks;
    repeat (64) begin
      @(posedge mclk_in);
      nj += int'(o[2] !== clks[2]);
      nr += int'(o[1] !== clks[1]);
      nt += int'(o[0] !== clks[0]);
      o = clks;
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #6_000_000;
    err_total++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk_rd(5'h00, 8'h00);
    chk_rd(5'h01, 8'h00);
    `CHK("lim", 1'b1, current_limit_enable_out)
    `CHK("rzs", 1'b1, rx_zero_subst_enable_out)
    `CHK("tzs", 1'b1, tx_zero_subst_enable_out)
    wr(5'h01, 8'h2F);
    chk_rd(5'h01, 8'h2F);
    `CHK("lim", 1'b0, current_limit_enable_out)
    `CHK("rzs", 1'b0, rx_zero_subst_enable_out)
    `CHK("tzs", 1'b0, tx_zero_subst_enable_out)
    `CHK("tx_positive_rail", 1'b0, tx_sampled_pos_out)
    `CHK("tx_negative_rail", 1'b1, tx_sampled_neg_out)
    wr(5'h05, 8'hFF);
    chk_rd(5'h05, 8'h00);
    chk_rd(5'h00, 8'h00);
    wr(5'h00, 8'h80);
    `CHK("ets", 1'b1, e1_t1_select_out)
    wr(5'h01, 8'h10);
    `CHK("tx_positive_rail", 1'b1, tx_sampled_pos_out)
    `CHK("sq", 1'b1, square_wave_out)
    `CHK("od", 1'b0, open_drain_out)
    build_out_select_in <= 3'h5;
    repeat (4) @(posedge mclk_in);
    `CHK("sq", 1'b0, square_wave_out)
    `CHK("od", 1'b1, open_drain_out)
    wr(5'h00, 8'h00);
    tog();
    `CHK("jmck", 1'b1, nj > 0)
    `CHK("rrec", 1'b1, nr == 0)
    wr(5'h00, 8'h08);
    tog();
    `CHK("jpll0", 1'b1, nj == 0)
    pll_en <= 1'b1;
    tog();
    `CHK("jpll1", 1'b1, nj > 0)
    pll_en <= 1'b0;
    wr(5'h00, 8'h0C);
    tog();
    `CHK("jtx", 1'b1, nj > 0)
    wr(5'h00, 8'h02);
    tog();
    `CHK("rtx", 1'b1, nr > 0)
    tx_run <= 1'b0;
    wr(5'h01, 8'h80);
    repeat (60) @(posedge mclk_in);
    `CHK("alm", 1'b1, alarm_out)
    hardware_mode_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    `CHK("almhw", 1'b0, alarm_out)
    hardware_mode_in <= 1'b0;
    wr(5'h00, 8'h01);
    tog();
    `CHK("fail1", 1'b1, nt > 0)
    wr(5'h00, 8'h00);
    tog();
    `CHK("fail0", 1'b1, nt == 0)
    tx_run <= 1'b1;
    wr(5'h01, 8'h00);
    repeat (20) @(posedge mclk_in);
    `CHK("alm", 1'b0, alarm_out)
    sp = 1'b0;
    sn = 1'b0;
    bit1(1'b1, 1'b0);
    bit1(1'b0, 1'b0);
    `CHK("rrise", 1'b0, sp)
    repeat (2) bit1(1'b0, 1'b0);
    `CHK("bpos", 1'b1, sp)
    `CHK("bneg", 1'b0, sn)
    wr(5'h00, 8'h50);
    `CHK("nrz", 1'b1, nrz_format_enable_out)
    bit1(1'b0, 1'b1);
    bit1(1'b1, 1'b0);
    wr(5'h00, 8'h40);
    sn = 1'b0;
    bit1(1'b0, 1'b1);
    bit1(1'b0, 1'b1);
    bit1(1'b1, 1'b0);
    bit1(1'b1, 1'b1);
    `CHK("nrzev", 1'b1, sn)
    wr(5'h00, 8'h50);
    bit1(1'b0, 1'b1);
    bit1(1'b1, 1'b0);
    bit1(1'b0, 1'b1);
    chk_rd(5'h11, 8'h00);
    chk_rd(5'h12, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, cfg[i]);
      bit1(1'b1, 1'b0);
      repeat (zn[i] - 1) bit1(1'b0, 1'b0);
      `CHK("cl", 1'b0, carrier_loss_out)
      bit1(1'b0, 1'b0);
      repeat (6) @(posedge mclk_in);
      `CHK("cl", 1'b1, carrier_loss_out)
      `CHK("almcl", 1'b1, alarm_out)
    end
    wr(5'h01, 8'h01);
    sp = 1'b0;
    bit1(1'b1, 1'b0);
    bit1(1'b0, 1'b0);
    `CHK("rfall", 1'b1, sp)
    give_verdict();
  end
endmodule
